// File: core/mpfs_top.sv
// monitor pin function select: axi4-lite registers, three pin decoders
// assumes comparator levels asynchronous, pins driven by pad logic outside
`timescale 1ns/10ps
module mpfs_top (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // axi4-lite slave
  input  wire logic [7:0]          awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [7:0]          araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  // pin levels and comparators (async)
  input  wire logic                monitorPinOneLevel,
  input  wire logic                monitorPinTwoLevel,
  input  wire logic                monitorPinThreeLevel,
  input  wire mpfs_pkg::mpfs_cmp_s cmpOne,
  input  wire mpfs_pkg::mpfs_cmp_s cmpTwo,
  input  wire mpfs_pkg::mpfs_cmp_s cmpThree,
  // dedicated functions
  output logic                     mainsSenseInputA,
  output logic                     mainsSenseInputB,
  output logic                     powerOnRequest,
  // indications and interrupt
  output mpfs_pkg::mpfs_ind_s      indOne,
  output mpfs_pkg::mpfs_ind_s      indTwo,
  output mpfs_pkg::mpfs_ind_s      indThree,
  output logic                     irq
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: 3 comparator bits + level per pin
  logic [11:0] syncA_reg;
  logic [11:0] syncB_reg;
  logic [11:0] rawIn;
  assign rawIn = {monitorPinThreeLevel, cmpThree, monitorPinTwoLevel, cmpTwo,
                  monitorPinOneLevel, cmpOne};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= rawIn;     // RULE11
      syncB_reg <= syncA_reg; // RULE11
    end
  end

  mpfs_pkg::mpfs_cmp_s cmpSyncOne;
  mpfs_pkg::mpfs_cmp_s cmpSyncTwo;
  mpfs_pkg::mpfs_cmp_s cmpSyncThree;
  logic                lvlOne;
  logic                lvlTwo;
  logic                lvlThree;
  assign cmpSyncOne   = syncB_reg[2:0];
  assign lvlOne       = syncB_reg[3];
  assign cmpSyncTwo   = syncB_reg[6:4];
  assign lvlTwo       = syncB_reg[7];
  assign cmpSyncThree = syncB_reg[10:8];
  assign lvlThree     = syncB_reg[11];

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [7:0] sel1_reg;
  logic [7:0] sel2_reg;
  logic [8:0] mask_reg;
  logic [8:0] irq_reg;
  logic [2:0] codeOne;
  logic [2:0] codeTwo;
  logic [2:0] codeThree;

  assign codeOne   = sel1_reg[mpfs_pkg::P1_LSB +: mpfs_pkg::SEL_W]; // RULE1
  assign codeTwo   = sel1_reg[mpfs_pkg::P2_LSB +: mpfs_pkg::SEL_W]; // RULE2
  assign codeThree = sel2_reg[mpfs_pkg::P3_LSB +: mpfs_pkg::SEL_W]; // RULE3

  function automatic logic isDedicated(input logic [2:0] code);
    isDedicated = (code == mpfs_pkg::CODE_DED0) || (code == mpfs_pkg::CODE_DED1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per pin decode
  mpfs_pkg::mpfs_ind_s rawOne;
  mpfs_pkg::mpfs_ind_s rawTwo;
  mpfs_pkg::mpfs_ind_s rawThree;

  mpfs_decode uDecOne (
    .mclk    (mclk),
    .rst     (rst),
    .selCode (codeOne),
    .cmpSync (cmpSyncOne),
    .ind     (rawOne)
  );
  mpfs_decode uDecTwo (
    .mclk    (mclk),
    .rst     (rst),
    .selCode (codeTwo),
    .cmpSync (cmpSyncTwo),
    .ind     (rawTwo)
  );
  mpfs_decode uDecThree (
    .mclk    (mclk),
    .rst     (rst),
    .selCode (codeThree),
    .cmpSync (cmpSyncThree),
    .ind     (rawThree)
  );

  // decoder yields zero for dedicated codes already
  assign indOne   = rawOne;
  assign indTwo   = rawTwo;
  assign indThree = rawThree;

  ////////////////////////////////////////////////////////////////////////////
  // dedicated functions, registered
  logic mainsA_next;
  logic mainsB_next;
  logic pwrOn_next;
  assign mainsA_next = isDedicated(codeOne) & lvlOne; // RULE1
  assign mainsB_next = isDedicated(codeTwo) & lvlTwo; // RULE2
  assign pwrOn_next  = (codeThree == mpfs_pkg::CODE_DED0) ? ~lvlThree : // RULE3
                       (codeThree == mpfs_pkg::CODE_DED1) ?  lvlThree : // RULE4
                       1'b0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mainsSenseInputA <= 1'b0;
      mainsSenseInputB <= 1'b0;
      powerOnRequest   <= 1'b0;
    end else begin
      mainsSenseInputA <= mainsA_next;
      mainsSenseInputB <= mainsB_next;
      powerOnRequest   <= pwrOn_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events: rising edge of any indication
  logic [8:0] indNow;
  logic [8:0] indPrev_reg;
  logic [8:0] irqEvent;
  assign indNow   = {indThree, indTwo, indOne};
  assign irqEvent = indNow & ~indPrev_reg;
  assign irq      = |(irq_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write: take address and data in either order
  logic        awHeld_reg;
  logic        wHeld_reg;
  logic [7:0]  awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        doWrite;
  logic        wrMapped;
  logic        wrLane0;
  logic [8:0]  w1c;

  assign awready  = ~awHeld_reg & ~bvalid;
  assign wready   = ~wHeld_reg & ~bvalid;
  assign doWrite  = awHeld_reg & wHeld_reg & ~bvalid;
  assign wrMapped = (awAddr_reg == mpfs_pkg::ADDR_SEL1) ||
                    (awAddr_reg == mpfs_pkg::ADDR_SEL2) ||
                    (awAddr_reg == mpfs_pkg::ADDR_IRQ)  ||
                    (awAddr_reg == mpfs_pkg::ADDR_MASK);
  assign wrLane0  = wStrb_reg[0];
  assign w1c      = (doWrite && awAddr_reg == mpfs_pkg::ADDR_IRQ) ?
                    {wStrb_reg[1] & wData_reg[8], {8{wrLane0}} & wData_reg[7:0]} : 9'h000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHeld_reg  <= 1'b0;
      wHeld_reg   <= 1'b0;
      awAddr_reg  <= 8'h00;
      wData_reg   <= 32'h0000_0000;
      wStrb_reg   <= 4'h0;
      bvalid      <= 1'b0;
      bresp       <= mpfs_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= wrMapped ? mpfs_pkg::RESP_OKAY : mpfs_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // register storage; set wins over write-one-to-clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel1_reg    <= mpfs_pkg::SEL1_RESET;
      sel2_reg    <= mpfs_pkg::SEL2_RESET;
      mask_reg    <= mpfs_pkg::MASK_RESET;
      irq_reg     <= 9'h000;
      indPrev_reg <= 9'h000;
    end else begin
      indPrev_reg <= indNow;
      irq_reg     <= (irq_reg & ~w1c) | irqEvent;
      if (doWrite && wrLane0 && awAddr_reg == mpfs_pkg::ADDR_SEL1) begin
        sel1_reg <= wData_reg[7:0];
      end
      if (doWrite && wrLane0 && awAddr_reg == mpfs_pkg::ADDR_SEL2) begin
        sel2_reg <= wData_reg[7:0];
      end
      if (doWrite && awAddr_reg == mpfs_pkg::ADDR_MASK) begin
        if (wrLane0) begin
          mask_reg[7:0] <= wData_reg[7:0];
        end
        if (wStrb_reg[1]) begin
          mask_reg[8] <= wData_reg[8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read
  logic        rdMapped;
  logic [31:0] rdWord;
  assign arready  = ~rvalid;
  assign rdMapped = (araddr == mpfs_pkg::ADDR_SEL1) || (araddr == mpfs_pkg::ADDR_SEL2) ||
                    (araddr == mpfs_pkg::ADDR_STATUS) || (araddr == mpfs_pkg::ADDR_IRQ) ||
                    (araddr == mpfs_pkg::ADDR_MASK);
  assign rdWord   = (araddr == mpfs_pkg::ADDR_SEL1)   ? {24'h000000, sel1_reg} :
                    (araddr == mpfs_pkg::ADDR_SEL2)   ? {24'h000000, sel2_reg} :
                    (araddr == mpfs_pkg::ADDR_STATUS) ?
                      {20'h00000, powerOnRequest, mainsSenseInputB, mainsSenseInputA, indNow} :
                    (araddr == mpfs_pkg::ADDR_IRQ)    ? {23'h0, irq_reg} :
                    (araddr == mpfs_pkg::ADDR_MASK)   ? {23'h0, mask_reg} :
                    32'h0000_0000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= mpfs_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rdWord;
      rresp  <= rdMapped ? mpfs_pkg::RESP_OKAY : mpfs_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// File: core/mpfs_pkg.sv
// package for the monitor pin function select block
// assumes one 100 MHz clock and comparator levels already digital
// Operation
// [RULE1] pin one select field is bits 3..1; codes 000/001 make it mains sense a.
// [RULE2] pin two select field is bits 7..5; codes 000/001 make it mains sense b.
// [RULE3] pin three select field is bits 4..2; code 000 is power-on request, active low.
// [RULE4] pin three code 001 is power-on request, active high.
// [RULE5] code 010: above 1.25 V flag and over set; below 1.15 V both clear.
// [RULE6] code 011: below 1.25 V only under set; above 1.35 V only flag set.
// [RULE7] code 100: below 1.25 V only over set; above 1.35 V only flag set.
// [RULE8] code 101: below 1.15 V all clear; above 1.25 V flag and under set.
// [RULE9] one shared decoder serves every monitor pin; mpfs_top instead has one mpfs_decode instance per pin, three in all.
// [RULE10] code 110 flag follows level; 111 inverts it; over and under stay clear.
// [RULE11] comparator results are synchronised to mclk before decode.
package mpfs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0] ADDR_SEL1   = 8'h00;
  localparam logic [7:0] ADDR_SEL2   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ    = 8'h0c;
  localparam logic [7:0] ADDR_MASK   = 8'h10;

  // field positions
  localparam int P1_LSB = 1;
  localparam int P2_LSB = 5;
  localparam int P3_LSB = 2;
  localparam int SEL_W  = 3;

  localparam logic [7:0] SEL1_RESET = 8'h00;
  localparam logic [7:0] SEL2_RESET = 8'h00;
  localparam logic [8:0] MASK_RESET = 9'h000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // select codes
  localparam logic [2:0] CODE_DED0 = 3'h0;
  localparam logic [2:0] CODE_DED1 = 3'h1;
  localparam logic [2:0] CODE_POV  = 3'h2;
  localparam logic [2:0] CODE_PUV  = 3'h3;
  localparam logic [2:0] CODE_NOV  = 3'h4;
  localparam logic [2:0] CODE_NUV  = 3'h5;
  localparam logic [2:0] CODE_FLAG = 3'h6;
  localparam logic [2:0] CODE_FLGN = 3'h7;

  // comparator inputs per pin: lo115 = above 1.15 V, mid125 = above 1.25 V,
  // hi135 = above 1.35 V
  typedef struct packed {
    logic hi135;
    logic mid125;
    logic lo115;
  } mpfs_cmp_s;

  typedef struct packed {
    logic flag;
    logic over;
    logic under;
  } mpfs_ind_s;

endpackage

// File: core/mpfs_decode.sv
// one monitor pin: hysteretic decode of comparator levels
// assumes comparator inputs already synchronised to mclk
`timescale 1ns/10ps
module mpfs_decode (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // configuration and level
  input  wire logic [2:0]        selCode,
  input  wire mpfs_pkg::mpfs_cmp_s cmpSync,
  // indications
  output mpfs_pkg::mpfs_ind_s    ind
);

  // hysteresis state: high after crossing the upper threshold
  logic       hyst_reg;
  logic       hyst_next;
  logic       upper;
  logic       lower;
  logic       highBand;
  mpfs_pkg::mpfs_ind_s ind_next;

  // thresholds per code; one instance of this decoder per pin
  assign highBand = (selCode == mpfs_pkg::CODE_PUV) || (selCode == mpfs_pkg::CODE_NOV);
  assign upper    = highBand ? cmpSync.hi135 : cmpSync.mid125; // RULE9
  assign lower    = highBand ? ~cmpSync.mid125 : ~cmpSync.lo115;
  assign hyst_next = upper ? 1'b1 : (lower ? 1'b0 : hyst_reg);

  always_comb begin
    ind_next = '0;
    case (selCode)
      mpfs_pkg::CODE_POV: begin
        ind_next.flag = hyst_next; // RULE5
        ind_next.over = hyst_next; // RULE5
      end
      mpfs_pkg::CODE_PUV: begin
        ind_next.flag  = hyst_next;  // RULE6
        ind_next.under = ~hyst_next; // RULE6
      end
      mpfs_pkg::CODE_NOV: begin
        ind_next.flag = hyst_next;  // RULE7
        ind_next.over = ~hyst_next; // RULE7
      end
      mpfs_pkg::CODE_NUV: begin
        ind_next.flag  = hyst_next; // RULE8
        ind_next.under = hyst_next; // RULE8
      end
      mpfs_pkg::CODE_FLAG: ind_next.flag = hyst_next;  // RULE10
      mpfs_pkg::CODE_FLGN: ind_next.flag = ~hyst_next; // RULE10
      default:             ind_next = '0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hyst_reg <= 1'b0;
      ind      <= '0;
    end else begin
      hyst_reg <= hyst_next;
      ind      <= ind_next;
    end
  end

endmodule

// File: test/mpfs_props.sv
// checker of bus handshakes and pin indications for mpfs_top
// assumes a bind onto mpfs_top and a single clock domain
`timescale 1ns/10ps
module mpfs_props (
  // clock and reset
  input wire logic                mclk,
  input wire logic                rst,
  // bus handshakes
  input wire logic                awvalid,
  input wire logic                awready,
  input wire logic                wvalid,
  input wire logic                wready,
  input wire logic                bvalid,
  input wire logic                bready,
  input wire logic                arvalid,
  input wire logic                arready,
  input wire logic                rvalid,
  input wire logic                rready,
  input wire logic [31:0]         rdata,
  // pins
  input wire logic                monitorPinOneLevel,
  input wire logic                monitorPinTwoLevel,
  input wire logic                mainsSenseInputA,
  input wire logic                mainsSenseInputB,
  input wire mpfs_pkg::mpfs_cmp_s cmpOne,
  input wire mpfs_pkg::mpfs_cmp_s cmpTwo,
  input wire mpfs_pkg::mpfs_ind_s indOne,
  input wire mpfs_pkg::mpfs_ind_s indTwo
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  sequence sWrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  // both channels refused while the write is in flight
  sequence sWrAnswer;
    !awready && !wready ##1 bvalid;
  endsequence
  AST_WR_RESP: assert property (sWrTaken |=> sWrAnswer)
    else $error("write response not on time");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  AST_RD_NEXT: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data not on next cycle");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  ////////////////////////////////////////////////////////////
  // three flop path: level sampled, synchronised, registered
  AST_MAINS_A: assert property (mainsSenseInputA |-> $past(monitorPinOneLevel, 3))
    else $error("mains sense a without pin level");
  AST_MAINS_B: assert property (mainsSenseInputB |-> $past(monitorPinTwoLevel, 3))
    else $error("mains sense b without pin level");
  AST_OV_UV: assert property (!(indOne.over && indOne.under))
    else $error("over and under together");
  AST_POV_SET: assert property (indOne.flag && indOne.over |-> $past(cmpOne.lo115, 3))
    else $error("over flag kept below lower level");
  AST_PUV_LOW: assert property (indOne.under && !indOne.flag |-> !$past(cmpOne.hi135, 3))
    else $error("under kept above upper level");
  AST_NOV_LOW: assert property (indOne.over && !indOne.flag |-> !$past(cmpOne.hi135, 3))
    else $error("over kept above upper level");
  AST_NUV_SET: assert property (indTwo.flag && indTwo.under |-> $past(cmpTwo.lo115, 3))
    else $error("under flag kept below lower level");
endmodule

bind mpfs_top mpfs_props chk_u (
  .mclk, .rst, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .arvalid, .arready, .rvalid, .rready, .rdata, .monitorPinOneLevel,
  .monitorPinTwoLevel, .mainsSenseInputA, .mainsSenseInputB, .cmpOne,
  .cmpTwo, .indOne, .indTwo
);

// File: test/test_monitor_pin_function_select.sv
// self-checking bench for the monitor pin function select block
// assumes mpfs_top with its checker bound in, one 100 MHz clock
`timescale 1ns/10ps
module test_monitor_pin_function_select;
  logic                mclk = 1'b0;
  logic                rst = 1'b1;
  logic [7:0]          awaddr = 8'h00;
  logic [7:0]          araddr = 8'h00;
  logic [31:0]         wdata = 32'h00000000;
  logic [3:0]          wstrb = 4'hf;
  logic                awvalid = 1'b0;
  logic                wvalid = 1'b0;
  logic                bready = 1'b0;
  logic                arvalid = 1'b0;
  logic                rready = 1'b0;
  logic                monitorPinOneLevel = 1'b0;
  logic                monitorPinTwoLevel = 1'b0;
  logic                monitorPinThreeLevel = 1'b0;
  mpfs_pkg::mpfs_cmp_s cmpOne = 3'h0;
  mpfs_pkg::mpfs_cmp_s cmpTwo = 3'h0;
  mpfs_pkg::mpfs_cmp_s cmpThree = 3'h0;
  logic                awready, wready, bvalid, arready, rvalid, irq;
  logic                mainsSenseInputA, mainsSenseInputB, powerOnRequest;
  logic [1:0]          bresp, rresp;
  logic [31:0]         rdata;
  mpfs_pkg::mpfs_ind_s indOne, indTwo, indThree;
  int                  miscompares = 0;
  int                  nCompared = 0;

  mpfs_top dut_u (
    .mclk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .monitorPinOneLevel, .monitorPinTwoLevel,
    .monitorPinThreeLevel, .cmpOne, .cmpTwo, .cmpThree, .mainsSenseInputA,
    .mainsSenseInputB, .powerOnRequest, .indOne, .indTwo, .indThree, .irq
  );

  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic stuck(input int n);
    if (n > 40) begin
      miscompares++;
      end_of_test;
    end
  endtask

  // ready raised on the same edge as the answer appears, so the answer is taken at once and never held
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic ta, tw, tb;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    tb = 1'b0;
    while (!tb) begin
      @(negedge mclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      if (tb) chk(bresp, er);
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
      if (n == 2) bready <= 1'b1;
      stuck(n);
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int   n;
    logic ta, tr;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    tr = 1'b0;
    while (!tr) begin
      @(negedge mclk);
      ta = arvalid & arready;
      tr = rvalid & rready;
      if (tr) chk(rdata, ed);
      if (tr) chk(rresp, er);
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      n++;
      if (n == 1) rready <= 1'b1;
      stuck(n);
    end
    rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic lvl(input logic v, input logic [2:0] e);
    @(posedge mclk);
    monitorPinOneLevel <= v;
    monitorPinTwoLevel <= v;
    monitorPinThreeLevel <= v;
    repeat (3) @(posedge mclk);
    #1;
    chk({powerOnRequest, mainsSenseInputB, mainsSenseInputA}, e);
  endtask

  task automatic pins(input logic [2:0] c, input logic [2:0] e);
    @(posedge mclk);
    cmpOne <= c;
    cmpTwo <= c;
    cmpThree <= c;
    repeat (3) @(posedge mclk);
    #1;
    chk(indOne, e);
    chk(indTwo, e);
    chk(indThree, e);
  endtask

  task automatic regsAtReset;
    rd(mpfs_pkg::ADDR_SEL1, 32'h00000000, 2'h0);
    rd(mpfs_pkg::ADDR_SEL2, 32'h00000000, 2'h0);
    rd(mpfs_pkg::ADDR_MASK, 32'h00000000, 2'h0);
    rd(8'h14, 32'h00000000, 2'h2);
    wr(8'h14, 32'hffffffff, 2'h2);
    wr(mpfs_pkg::ADDR_MASK, 32'h000003ff, 2'h0);
    rd(mpfs_pkg::ADDR_MASK, 32'h000001ff, 2'h0);
    // lane 1 alone clears bit 8 and leaves bits 7..0
    wstrb <= 4'h2;
    wr(mpfs_pkg::ADDR_MASK, 32'h00000000, 2'h0);
    rd(mpfs_pkg::ADDR_MASK, 32'h000000ff, 2'h0);
    wstrb <= 4'hf;
    wr(mpfs_pkg::ADDR_MASK, 32'h00000000, 2'h0);
  endtask

  task automatic dedicated;
    lvl(1'b1, 3'h3);
    lvl(1'b0, 3'h4);
    wr(mpfs_pkg::ADDR_SEL1, 32'h00000022, 2'h0);
    wr(mpfs_pkg::ADDR_SEL2, 32'h00000004, 2'h0);
    rd(mpfs_pkg::ADDR_SEL1, 32'h00000022, 2'h0);
    lvl(1'b1, 3'h7);
    rd(mpfs_pkg::ADDR_STATUS, 32'h00000e00, 2'h0);
    lvl(1'b0, 3'h0);
    wr(mpfs_pkg::ADDR_SEL1, 32'h00000044, 2'h0);
    wr(mpfs_pkg::ADDR_SEL2, 32'h00000008, 2'h0);
    lvl(1'b1, 3'h0);
  endtask

  // mid level sits between thresholds, so it must keep the last state
  task automatic monCase(input logic [2:0] c, input logic [2:0] mid,
                         input logic [2:0] lo, input logic [2:0] hi);
    wr(mpfs_pkg::ADDR_SEL1, {24'h000000, c, 1'b0, c, 1'b0}, 2'h0);
    wr(mpfs_pkg::ADDR_SEL2, {27'h0, c, 2'h0}, 2'h0);
    pins(3'h0, lo);
    pins(mid, lo);
    pins(3'h7, hi);
    pins(mid, hi);
    pins(3'h0, lo);
  endtask

  task automatic irqFlow;
    wr(mpfs_pkg::ADDR_SEL1, 32'h000000cc, 2'h0);
    wr(mpfs_pkg::ADDR_SEL2, 32'h00000018, 2'h0);
    wr(mpfs_pkg::ADDR_IRQ, 32'h000001ff, 2'h0);
    rd(mpfs_pkg::ADDR_IRQ, 32'h00000000, 2'h0);
    wr(mpfs_pkg::ADDR_MASK, 32'h00000004, 2'h0);
    pins(3'h7, 3'h4);
    // status bit lands one edge after the indication rises
    @(posedge mclk);
    #1;
    chk(irq, 1'b1);
    rd(mpfs_pkg::ADDR_IRQ, 32'h00000124, 2'h0);
    wr(mpfs_pkg::ADDR_MASK, 32'h00000000, 2'h0);
    #1;
    chk(irq, 1'b0);
    wr(mpfs_pkg::ADDR_MASK, 32'h00000020, 2'h0);
    #1;
    chk(irq, 1'b1);
    wr(mpfs_pkg::ADDR_IRQ, 32'h00000020, 2'h0);
    #1;
    chk(irq, 1'b0);
    rd(mpfs_pkg::ADDR_IRQ, 32'h00000104, 2'h0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    regsAtReset;
    dedicated;
    monCase(3'h2, 3'h1, 3'h0, 3'h6);
    monCase(3'h3, 3'h3, 3'h1, 3'h4);
    monCase(3'h4, 3'h3, 3'h2, 3'h4);
    monCase(3'h5, 3'h1, 3'h0, 3'h5);
    monCase(3'h6, 3'h1, 3'h0, 3'h4);
    monCase(3'h7, 3'h1, 3'h4, 3'h0);
    irqFlow;
    end_of_test;
  end
endmodule
